/* logic/dimc_config_regs.v */
// configuration, command and input snapshot logic of the digital input module
// Operation
// R01 - slave address 1..DF, protected, factory 0001
// R02 - decode baud and parity fields, factory 0035
// R03 - response delay ms, capped at 63
// R04 - wait response delay before replying
// R05 - extra end-of-query wait, capped at 48
// R06 - delay register protected, factory 0003
// R07 - read-only code version, writes ignored
// R08 - command 1 resets only when enabled
// R09 - command 3 snapshots all inputs together
// R10 - command 5 applies stored comm settings
// R11 - protected writes need command 2 first
// R12 - inputs readable as coils, codes 01/02
// R13 - enable cleared after protected write, reset
`timescale 1ns/1ps
`default_nettype none
`include "dimc_defs.vh"
module dimc_config_regs #(
  parameter [31:0] MS_CYCLES    = `DIMC_CLK_HZ / `DIMC_MS_PER_S * `DIMC_MS_TIME,
  parameter [15:0] CODE_VERSION = 16'h0100  // arbitrary value
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // register port from the frame engine
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // coil port from the frame engine
  input  wire        coil_rd,
  input  wire [15:0] coil_addr,
  output reg         coil_data,
  output reg         coil_rvalid,
  // digital input pins
  input  wire [14:0] din_pin,
  // frame timing
  input  wire        char_gap_done,
  input  wire        rx_char,
  output reg         query_end,
  output reg         reply_go,
  // applied comm settings
  output reg  [7:0]  act_slave_addr,
  output reg  [15:0] act_baud_div,
  output reg         act_parity_en,
  output reg         act_parity_odd,
  output reg         act_two_stop,
  // soft reset of the rest of the module
  output reg         soft_reset
);

  // state codes of the delay sequencer
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_EOQ  = 2'h1;
  localparam [1:0] ST_RSP  = 2'h2;
  // baud divisors, kept full width and cut to 16 bits where used
  localparam [31:0] DIV_9600   = `DIMC_CLK_HZ / 9600;
  localparam [31:0] DIV_19200  = `DIMC_CLK_HZ / 19200;
  localparam [31:0] DIV_38400  = `DIMC_CLK_HZ / 38400;
  localparam [31:0] DIV_57600  = `DIMC_CLK_HZ / 57600;
  localparam [31:0] DIV_115200 = `DIMC_CLK_HZ / 115200;
  localparam [31:0] MS_LAST    = MS_CYCLES - 1;  // last divider count

  reg  [15:0] slave_addr_r;    // stored address
  reg  [15:0] serial_setup_r;  // stored serial setup
  reg  [15:0] bus_delays_r;    // stored delays
  reg         wren_r;          // write enable
  reg  [14:0] snap_r;          // synchronous snapshot
  reg  [14:0] s1_r;            // sync stage 1
  reg  [14:0] s2_r;            // sync stage 2
  reg  [14:0] s3_r;            // sync stage 3
  reg  [14:0] din_r;           // settled inputs
  reg  [7:0]  act_rsp_r;       // applied response delay
  reg  [7:0]  act_eoq_r;       // applied end-of-query delay
  reg  [1:0]  state_r;         // sequencer state
  reg  [17:0] tick_cnt_r;      // ms divider
  reg  [7:0]  ms_left_r;       // ms remaining
  reg         apply_r;         // apply settings next cycle
  wire        ms_tick;         // one-cycle ms pulse
  wire        prot_hit;        // write to a protected register
  wire        cmd_hit;         // write to the command word
  wire [7:0]  rsp_lim;         // capped response delay
  wire [7:0]  eoq_lim;         // capped end-of-query delay
  reg  [15:0] baud_div_nxt;    // decoded divisor

  assign prot_hit = reg_wr && (reg_addr == `DIMC_OFS_SLAVE_ADDRESS ||
                               reg_addr == `DIMC_OFS_SERIAL_SETUP ||
                               reg_addr == `DIMC_OFS_BUS_DELAYS);
  assign cmd_hit  = reg_wr && (reg_addr == `DIMC_OFS_COMMAND_WORD);
  // caps on the delay fields
  assign rsp_lim = (bus_delays_r[`DIMC_RSP_MSB:`DIMC_RSP_LSB] > `DIMC_RSP_MAX_MS) ?
                   `DIMC_RSP_MAX_MS : bus_delays_r[`DIMC_RSP_MSB:`DIMC_RSP_LSB]; // R03
  assign eoq_lim = (bus_delays_r[`DIMC_EOQ_MSB:`DIMC_EOQ_LSB] > `DIMC_EOQ_MAX_MS) ?
                   `DIMC_EOQ_MAX_MS : bus_delays_r[`DIMC_EOQ_MSB:`DIMC_EOQ_LSB]; // R05

  // three-stage input synchroniser per bit
  genvar gi;
  generate
    for (gi = 0; gi < `DIMC_NUM_INPUTS; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          s1_r[gi]  <= 1'b0;
          s2_r[gi]  <= 1'b0;
          s3_r[gi]  <= 1'b0;
          din_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= din_pin[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          // change taken once stages two and three agree
          if (s2_r[gi] == s3_r[gi])
            din_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  // stored registers, write enable and commands
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      slave_addr_r   <= `DIMC_RST_SLAVE_ADDRESS;
      serial_setup_r <= `DIMC_RST_SERIAL_SETUP;
      bus_delays_r   <= `DIMC_RST_BUS_DELAYS;
      wren_r         <= 1'b0;
      snap_r         <= 15'h0000;
      soft_reset     <= 1'b0;
      apply_r        <= 1'b0;
    end
    else
    begin
      soft_reset <= 1'b0;
      apply_r    <= 1'b0;
      if (soft_reset)
      begin
        // soft reset drops the enable and reapplies settings
        wren_r  <= 1'b0; // R13
        apply_r <= 1'b1;
      end
      else if (prot_hit && wren_r)
      begin
        // one protected write per enable
        wren_r <= 1'b0; // R13
        case (reg_addr)
          `DIMC_OFS_SLAVE_ADDRESS:
          begin
            // out-of-range addresses are dropped
            if (reg_wdata >= `DIMC_ADDR_MIN && reg_wdata <= `DIMC_ADDR_MAX)
              slave_addr_r <= reg_wdata; // R01
          end
          `DIMC_OFS_SERIAL_SETUP:
            serial_setup_r <= reg_wdata; // R02
          `DIMC_OFS_BUS_DELAYS:
            bus_delays_r <= reg_wdata; // R06
          default:
            wren_r <= 1'b0;
        endcase
      end
      else if (cmd_hit)
      begin
        case (reg_wdata)
          `DIMC_CMD_WREN:
            wren_r <= 1'b1; // R11
          `DIMC_CMD_RESET:
          begin
            // remote reset is itself protected
            if (wren_r)
              soft_reset <= 1'b1; // R08
          end
          `DIMC_CMD_SAMPLE:
            snap_r <= din_r; // R09
          `DIMC_CMD_INIT:
            apply_r <= 1'b1; // R10
          default:
            wren_r <= wren_r;  // no_action_command and unknown codes
        endcase
      end
      // writes to the code version fall through untouched R07
    end
  end

  // baud code decode, unknown codes fall back to 9600
  always @*
  begin
    case (serial_setup_r[`DIMC_BAUD_MSB:`DIMC_BAUD_LSB])
      `DIMC_BAUD_19200:  baud_div_nxt = DIV_19200[15:0];
      `DIMC_BAUD_38400:  baud_div_nxt = DIV_38400[15:0];
      `DIMC_BAUD_57600:  baud_div_nxt = DIV_57600[15:0];
      `DIMC_BAUD_115200: baud_div_nxt = DIV_115200[15:0];
      default:           baud_div_nxt = DIV_9600[15:0];
    endcase
  end
  // applied settings, loaded at reset values and on apply
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      act_slave_addr <= 8'h01;
      act_baud_div   <= DIV_9600[15:0];
      act_parity_en  <= 1'b0;
      act_parity_odd <= 1'b0;
      act_two_stop   <= 1'b0;
      act_rsp_r      <= 8'h03;
      act_eoq_r      <= 8'h00;
    end
    else if (apply_r)
    begin
      act_slave_addr <= slave_addr_r[7:0]; // R10
      act_baud_div   <= baud_div_nxt; // R02
      // odd and even codes are the two with unequal bits, so parity is on for the xor of the field
      act_parity_en  <= ^serial_setup_r[`DIMC_PAR_MSB:`DIMC_PAR_LSB]; // R02
      act_parity_odd <= (serial_setup_r[`DIMC_PAR_MSB:`DIMC_PAR_LSB] == `DIMC_PAR_ODD); // R02
      act_two_stop   <= (serial_setup_r[`DIMC_PAR_MSB:`DIMC_PAR_LSB] == `DIMC_PAR_NONE2); // R02
      act_rsp_r <= rsp_lim; // R03
      act_eoq_r <= eoq_lim; // R05
    end
  end
  // register read answer, one cycle after the strobe
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `DIMC_OFS_SLAVE_ADDRESS: reg_rdata <= slave_addr_r;
          `DIMC_OFS_SERIAL_SETUP:  reg_rdata <= serial_setup_r;
          `DIMC_OFS_BUS_DELAYS:    reg_rdata <= bus_delays_r;
          `DIMC_OFS_CODE_VERSION:  reg_rdata <= CODE_VERSION; // R07
          default:                 reg_rdata <= 16'h0000;  // command word, unmapped
        endcase
      end
    end
  end
  // coil read answer, live inputs and snapshot
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      coil_data   <= 1'b0;
      coil_rvalid <= 1'b0;
    end
    else
    begin
      coil_rvalid <= coil_rd;
      if (coil_rd)
      begin
        if (coil_addr[15:4] == `DIMC_COIL_LIVE_BASE >> 4 && coil_addr[3:0] != 4'hF)
          coil_data <= din_r[coil_addr[3:0]]; // R12
        else if (coil_addr[15:4] == `DIMC_COIL_SNAP_BASE >> 4 && coil_addr[3:0] != 4'hF)
          coil_data <= snap_r[coil_addr[3:0]]; // R12
        else
          coil_data <= 1'b0;
      end
    end
  end
  // millisecond divider, held at zero while the sequencer is idle
  assign ms_tick = (tick_cnt_r == MS_LAST[17:0]);
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      tick_cnt_r <= 18'h00000;
    else if (state_r == ST_IDLE || ms_tick)
      tick_cnt_r <= 18'h00000;
    else
      tick_cnt_r <= tick_cnt_r + 18'h00001;
  end
  // end-of-query and response delay sequencer
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= ST_IDLE;
      ms_left_r <= 8'h00;
      query_end <= 1'b0;
      reply_go  <= 1'b0;
    end
    else
    begin
      query_end <= 1'b0;
      reply_go  <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          // idle gap seen, start the extra wait
          if (char_gap_done)
          begin
            state_r   <= ST_EOQ;
            ms_left_r <= act_eoq_r; // R05
          end
        end
        ST_EOQ:
        begin
          if (rx_char)
            state_r <= ST_IDLE;  // message continues
          else if (ms_left_r == 8'h00)
          begin
            query_end <= 1'b1; // R05
            state_r   <= ST_RSP;
            ms_left_r <= act_rsp_r; // R04
          end
          else if (ms_tick)
            ms_left_r <= ms_left_r - 8'h01;
        end
        ST_RSP:
        begin
          // hold the reply until the response delay has run out
          if (ms_left_r == 8'h00)
          begin
            reply_go <= 1'b1; // R04
            state_r  <= ST_IDLE;
          end
          else if (ms_tick)
            ms_left_r <= ms_left_r - 8'h01;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* logic/dimc_defs.vh */
// constants for the digital input configuration register bank
`ifndef DIMC_DEFS_VH
`define DIMC_DEFS_VH
// register offsets on the frame engine register port
`define DIMC_OFS_SLAVE_ADDRESS 16'h9C41
`define DIMC_OFS_SERIAL_SETUP  16'h9C42
`define DIMC_OFS_BUS_DELAYS    16'h9C43
`define DIMC_OFS_CODE_VERSION  16'h9C61
`define DIMC_OFS_COMMAND_WORD  16'h9D31
// factory values
`define DIMC_RST_SLAVE_ADDRESS 16'h0001
`define DIMC_RST_SERIAL_SETUP  16'h0035
`define DIMC_RST_BUS_DELAYS    16'h0003
// slave address limits
`define DIMC_ADDR_MIN 16'h0001
`define DIMC_ADDR_MAX 16'h00DF
// serial setup fields
`define DIMC_BAUD_LSB 0
`define DIMC_BAUD_MSB 4
`define DIMC_PAR_LSB  5
`define DIMC_PAR_MSB  6
// baud codes
`define DIMC_BAUD_9600   5'h05
`define DIMC_BAUD_19200  5'h06
`define DIMC_BAUD_38400  5'h07
`define DIMC_BAUD_57600  5'h08
`define DIMC_BAUD_115200 5'h09
// parity codes
`define DIMC_PAR_NONE2 2'h0
`define DIMC_PAR_ODD   2'h1
`define DIMC_PAR_EVEN  2'h2
`define DIMC_PAR_NONE1 2'h3
// delay fields and limits in ms
`define DIMC_RSP_LSB 0
`define DIMC_RSP_MSB 7
`define DIMC_EOQ_LSB 8
`define DIMC_EOQ_MSB 15
`define DIMC_RSP_MAX_MS 8'h3F
`define DIMC_EOQ_MAX_MS 8'h30
// command codes
`define DIMC_CMD_NO_ACTION 16'h0000
`define DIMC_CMD_RESET  16'h0001
`define DIMC_CMD_WREN   16'h0002
`define DIMC_CMD_SAMPLE 16'h0003
`define DIMC_CMD_INIT   16'h0005
// coil addresses
`define DIMC_COIL_LIVE_BASE 16'h0000
`define DIMC_COIL_SNAP_BASE 16'h0100
`define DIMC_NUM_INPUTS     15
// timing
`define DIMC_CLK_HZ    250000000
`define DIMC_MS_PER_S  1000
`define DIMC_MS_TIME   1
`endif

/* tb/dimc_regs_chk_properties.sv */
// port checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "dimc_defs.vh"
module dimc_regs_chk #(
  parameter [31:0] MS_CYCLES    = 32'd4,
  parameter [15:0] CODE_VERSION = 16'h0100  // arbitrary value
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // register and coil ports
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        coil_rd,
  input wire logic [15:0] coil_addr,
  input wire logic        coil_data,
  // timing and applied settings
  input wire logic        query_end,
  input wire logic        reply_go,
  input wire logic [7:0]  act_slave_addr,
  input wire logic [15:0] act_baud_div,
  input wire logic        soft_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // command word writes by code
  wire cmd_wr  = reg_wr && reg_addr == `DIMC_OFS_COMMAND_WORD;
  wire rst_cmd = cmd_wr && reg_wdata == `DIMC_CMD_RESET;
  wire noact_cmd = cmd_wr && reg_wdata == `DIMC_CMD_NO_ACTION;
  wire app_cmd = cmd_wr && reg_wdata == `DIMC_CMD_INIT;
  logic wait_r;  // query ended, reply still owed
  // track the reply owed after each query end
  always @(posedge mclk or posedge rst)
    if (rst)
      wait_r <= 1'b0;
    else if (query_end)
      wait_r <= 1'b1;
    else if (reply_go)
      wait_r <= 1'b0;
  property p_version;
    reg_rd && reg_addr == `DIMC_OFS_CODE_VERSION |=> reg_rdata == CODE_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("version word wrong");
  property p_rd_answer;
    1'b1 |=> reg_rvalid == $past(reg_rd);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_srst_cause;
    soft_reset |-> $past(rst_cmd);
  endproperty
  a_srst_cause: assert property (p_srst_cause) else $error("stray soft reset");
  property p_no_action;
    noact_cmd |=> !soft_reset [*3];
  endproperty
  a_no_action: assert property (p_no_action) else $error("no-action did act");
  property p_act_hold;
    $changed(act_baud_div) || $changed(act_slave_addr) |-> $past(app_cmd, 2)
      || $past(app_cmd, 3) || $past(app_cmd, 4) || $past(soft_reset, 1)
      || $past(soft_reset, 2) || $past(soft_reset, 3);
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("settings moved alone");
  property p_addr_legal;
    act_slave_addr != 8'h00 && act_slave_addr <= 8'hDF;
  endproperty
  a_addr_legal: assert property (p_addr_legal) else $error("address out of range");
  property p_reply_order;
    reply_go |-> wait_r;
  endproperty
  a_reply_order: assert property (p_reply_order) else $error("reply before end");
  property p_coil_out;
    coil_rd && coil_addr > 16'h010E |=> !coil_data;
  endproperty
  a_coil_out: assert property (p_coil_out) else $error("unmapped coil set");
endmodule
bind dimc_config_regs dimc_regs_chk #(.MS_CYCLES(MS_CYCLES), .CODE_VERSION(CODE_VERSION))
  dimc_regs_chk_i (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .coil_rd, .coil_addr, .coil_data, .query_end, .reply_go, .act_slave_addr,
  .act_baud_div, .soft_reset);
`default_nettype wire

/* tb/dimc_frame_host.sv */
// frame engine stand-in: marks idle gaps and times the replies
`timescale 1ns/1ps
`default_nettype none
module dimc_frame_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // bench requests
  input  wire logic        go,
  input  wire logic        abort,
  // block timing pulses
  input  wire logic        query_end,
  input  wire logic        reply_go,
  output logic             char_gap_done,
  output logic             rx_char,
  // cycles counted from the gap
  output logic [15:0]      qe_lat,
  output logic [15:0]      rp_lat,
  output logic             done
);
  logic [15:0] cnt;  // cycles since gap
  // gap and late character pulses, latency capture
  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      {char_gap_done, rx_char, done, cnt, qe_lat, rp_lat} <= '0;
    end
    else
    begin
      char_gap_done <= go;
      rx_char       <= abort;
      cnt           <= go ? 16'h0000 : cnt + 16'h0001;
      if (go)
        done <= 1'b0;
      if (query_end)
        qe_lat <= cnt;
      if (reply_go)
      begin
        rp_lat <= cnt;
        done   <= 1'b1;
      end
    end
endmodule
`default_nettype wire

/* tb/test_dimc_config_regs.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "dimc_defs.vh"
module test_dimc_config_regs;
  localparam [31:0] MS  = 32'd4;      // short millisecond
  localparam [15:0] VER = 16'h2B7E;   // arbitrary value
  localparam [15:0] CW  = `DIMC_OFS_COMMAND_WORD;
  localparam [15:0] SA  = `DIMC_OFS_SLAVE_ADDRESS;
  localparam [15:0] BD  = `DIMC_OFS_BUS_DELAYS;
  localparam [14:0] SNP = 15'h2A5A;   // pins at the snapshot
  logic             mclk, rst, reg_wr, reg_rd, coil_rd, go, abort;
  logic [15:0]      reg_addr, reg_wdata, coil_addr;
  logic [14:0]      din_pin;
  wire logic [15:0] reg_rdata, act_baud_div, qe_lat, rp_lat;
  wire logic        reg_rvalid, coil_data, coil_rvalid, char_gap_done, rx_char, done;
  wire logic        query_end, reply_go, act_parity_en, act_parity_odd, act_two_stop;
  wire logic        soft_reset;
  wire logic [7:0]  act_slave_addr;
  int               fails, cmp_count, srst_cnt, srst_n, i;
  int               rate [5] = '{9600, 19200, 38400, 57600, 115200};
  dimc_config_regs #(.MS_CYCLES(MS), .CODE_VERSION(VER)) dimc_config_regs_i (
    .mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .coil_rd, .coil_addr, .coil_data, .coil_rvalid, .din_pin, .char_gap_done,
    .rx_char, .query_end, .reply_go, .act_slave_addr, .act_baud_div, .act_parity_en,
    .act_parity_odd, .act_two_stop, .soft_reset);
  dimc_frame_host dimc_frame_host_i (.mclk, .rst, .go, .abort, .query_end, .reply_go,
    .char_gap_done, .rx_char, .qe_lat, .rp_lat, .done);
  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // count soft reset pulses
  always @(posedge mclk)
    if (soft_reset === 1'b1)
      srst_cnt <= srst_cnt + 1;
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // enable, then one protected write
  task pw(input logic [15:0] a, d);
    wr(CW, `DIMC_CMD_WREN);
    wr(a, d);
  endtask
  task rd(input logic [15:0] a, e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rvalid", reg_rvalid, 1);
    chk("rdata", reg_rdata, e);
  endtask
  task crd(input logic [15:0] a, input logic e);
    @(posedge mclk);
    coil_rd   <= 1'b1;
    coil_addr <= a;
    @(posedge mclk);
    coil_rd <= 1'b0;
    #1 chk("coil", coil_data, e);
    chk("coil_rvalid", coil_rvalid, 1);
  endtask
  // one idle gap, optional late character, bounded wait for the reply
  task frame(input int q, r, input logic ab);
    int k;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go    <= 1'b0;
    abort <= ab;
    @(posedge mclk);
    abort <= 1'b0;
    for (k = 0; k < 700 && done !== 1'b1; k++)
      @(posedge mclk);
    #1;
    if (ab)
      chk("abort", done, 0);
    else if (done !== 1'b1)
    begin
      fails++;
      results;
    end
    else
    begin
      chk("qe", qe_lat >= q && qe_lat <= q + 5, 1);
      chk("rp", rp_lat - qe_lat >= r && rp_lat - qe_lat <= r + 4, 1);
    end
  endtask
  // main sequence
  initial
  begin
    {reg_wr, reg_rd, coil_rd, go, abort} = '0;
    {reg_addr, reg_wdata, coil_addr} = '0;
    din_pin  = '0;
    srst_cnt = 0;
    rst      = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(SA, 16'h0001);
    rd(`DIMC_OFS_SERIAL_SETUP, 16'h0035);
    rd(BD, 16'h0003);
    wr(`DIMC_OFS_CODE_VERSION, 16'hFFFF);
    rd(`DIMC_OFS_CODE_VERSION, VER);
    rd(CW, 16'h0000);
    rd(16'h9C44, 16'h0000);
    chk("baud", act_baud_div, `DIMC_CLK_HZ / 9600);
    frame(0, 3 * MS, 0);
    wr(SA, 16'h0005);
    rd(SA, 16'h0001);
    pw(SA, 16'h0005);
    rd(SA, 16'h0005);
    chk("act", act_slave_addr, 8'h01);
    wr(SA, 16'h0007);
    rd(SA, 16'h0005);
    pw(SA, 16'h00E0);
    wr(SA, 16'h0007);
    rd(SA, 16'h0005);
    pw(SA, 16'h00DF);
    rd(SA, 16'h00DF);
    for (i = 0; i < 5; i++)
    begin
      pw(`DIMC_OFS_SERIAL_SETUP, 16'((i % 4) * 32 + 5 + i));
      wr(CW, `DIMC_CMD_INIT);
      repeat (4) @(posedge mclk);
      #1 chk("baud", act_baud_div, `DIMC_CLK_HZ / rate[i]);
      chk("par", act_parity_en, i % 4 == 1 || i % 4 == 2);
      chk("odd", act_parity_odd, i % 4 == 1);
      chk("stop", act_two_stop, i % 4 == 0);
    end
    chk("act", act_slave_addr, 8'hDF);
    pw(BD, 16'h0050);
    wr(CW, `DIMC_CMD_INIT);
    rd(BD, 16'h0050);
    frame(0, 63 * MS, 0);
    pw(BD, 16'h3201);
    wr(CW, `DIMC_CMD_INIT);
    rd(BD, 16'h3201);
    frame(48 * MS, MS, 0);
    frame(0, 0, 1);
    din_pin <= SNP;
    repeat (6) @(posedge mclk);
    wr(CW, `DIMC_CMD_SAMPLE);
    din_pin <= ~SNP;
    repeat (6) @(posedge mclk);
    for (i = 0; i < 15; i++)
    begin
      crd(16'h0100 + 16'(i), SNP[i]);
      crd(16'(i), ~SNP[i]);
    end
    crd(16'h010F, 1'b0);
    srst_n = srst_cnt;
    wr(CW, `DIMC_CMD_RESET);
    wr(CW, `DIMC_CMD_NO_ACTION);
    repeat (3) @(posedge mclk);
    chk("srst", srst_cnt, srst_n);
    pw(CW, `DIMC_CMD_RESET);
    repeat (3) @(posedge mclk);
    chk("srst", srst_cnt, srst_n + 1);
    wr(SA, 16'h0009);
    rd(SA, 16'h00DF);
    results;
  end
endmodule
`default_nettype wire
